//--- irq_unit_pkg.sv
`default_nettype none
package irq_unit_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS  = 8'h0C;
  localparam logic [7:0] IDX_MASK    = 8'h0D;
  localparam logic [7:0] IDX_CONTROL = 8'h0E;
  localparam logic [7:0] IDX_PHY     = 8'h0F;

  // status and mask bit positions
  localparam int BIT_PHY     = 7;
  localparam int BIT_EARLY   = 6;
  localparam int BIT_EPH     = 5;
  localparam int BIT_ABORT   = 4;
  localparam int BIT_ALLOC   = 3;
  localparam int BIT_DRAINED = 2;
  localparam int BIT_TXC     = 1;
  localparam int BIT_RXP     = 0;

  // control register field positions
  localparam int CTL_THRESH_LSB = 0;
  localparam int CTL_THRESH_MSB = 4;
  localparam int CTL_DISCARD    = 7;
  localparam int CTL_LE         = 8;
  localparam int CTL_CR         = 9;
  localparam int CTL_TE         = 10;
  localparam int CTL_TRANSMIT_ENABLE      = 11;

  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h04;
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [4:0] THRESH_RESET = 5'h1F;

  // widths and units
  localparam int PHY_BITS     = 9;
  localparam int BYTE_CNT_W   = 11;
  localparam int THRESH_SHIFT = 6;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // byte address of a register index
  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx[5:0], 2'h0};
  endfunction : byte_addr
endpackage : irq_unit_pkg
`default_nettype wire

//--- ethernet_ctrl_interrupt_unit.sv
`timescale 1ns/100ps
`default_nettype none
module ethernet_ctrl_interrupt_unit (
  input  wire logic                                    clk,
  input  wire logic                                    rst,
  input  wire logic [7:0]                              s_axi_awaddr,
  input  wire logic                                    s_axi_awvalid,
  output logic                                         s_axi_awready,
  input  wire logic [31:0]                             s_axi_wdata,
  input  wire logic [3:0]                              s_axi_wstrb,
  input  wire logic                                    s_axi_wvalid,
  output logic                                         s_axi_wready,
  output logic [1:0]                                   s_axi_bresp,
  output logic                                         s_axi_bvalid,
  input  wire logic                                    s_axi_bready,
  input  wire logic [7:0]                              s_axi_araddr,
  input  wire logic                                    s_axi_arvalid,
  output logic                                         s_axi_arready,
  output logic [31:0]                                  s_axi_rdata,
  output logic [1:0]                                   s_axi_rresp,
  output logic                                         s_axi_rvalid,
  input  wire logic                                    s_axi_rready,
  input  wire logic [irq_unit_pkg::PHY_BITS-1:0]       phy_status_bits,
  input  wire logic                                    receiving,
  input  wire logic [irq_unit_pkg::BYTE_CNT_W-1:0]     rx_byte_count,
  input  wire logic                                    rx_alloc_overrun,
  input  wire logic                                    rx_too_long,
  input  wire logic                                    link_event,
  input  wire logic                                    counter_rollover,
  input  wire logic                                    counter_read,
  input  wire logic                                    transmit_underrun,
  input  wire logic                                    sqe_error,
  input  wire logic                                    carrier_lost,
  input  wire logic                                    late_collision,
  input  wire logic                                    sixteen_collisions,
  input  wire logic                                    frame_sent,
  input  wire logic                                    alloc_request,
  input  wire logic                                    alloc_failed,
  input  wire logic                                    tx_queue_empty,
  input  wire logic                                    completion_queue_empty,
  input  wire logic                                    receive_queue_empty,
  output logic                                         completion_pop,
  output logic                                         receive_discard,
  output logic                                         transmit_enable,
  output logic                                         transmit_success,
  output logic                                         irq
);
  import irq_unit_pkg::*;

  typedef struct packed {
    logic [7:0]          status;
    logic [7:0]          mask;
    logic [4:0]          thresh;
    logic                discard;
    logic                le_en;
    logic                cr_en;
    logic                te_en;
    logic                tx_en;
    logic                tx_success;
    logic                link_pend;
    logic                roll_pend;
    logic                err_pend;
    logic [PHY_BITS-1:0] phy_sync1;
    logic [PHY_BITS-1:0] phy_sync2;
    logic [PHY_BITS-1:0] phy_shown;
    logic                phy_held;
    logic                empty_prev;
    logic                pop;
    logic                aw_full;
    logic                w_full;
    logic [7:0]          awaddr;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } state_s;

  state_s s;
  state_s next_s;

  // decode helpers shared with the checks
  logic                  ack_fire;
  logic [7:0]            ack_val;
  logic                  mask_we;
  logic [7:0]            mask_val;
  logic                  phy_read;
  logic                  fatal;

  // threshold expressed in bytes
  function automatic logic [BYTE_CNT_W-1:0] thresh_bytes(input logic [4:0] t);
    thresh_bytes = {t, {THRESH_SHIFT{1'b0}}};
  endfunction : thresh_bytes

  // sticky flag update where a set beats a clear in the same cycle
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction : sticky

  // handshake outputs from state
  assign s_axi_awready = ~s.aw_full & ~s.bvalid;
  assign s_axi_wready  = ~s.w_full & ~s.bvalid;
  assign s_axi_arready = ~s.rvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign completion_pop   = s.pop;
  assign receive_discard  = s.discard;
  assign transmit_enable  = s.tx_en;
  assign transmit_success = s.tx_success;
  // level interrupt from registered status and mask
  assign irq = |(s.status & s.mask);

  // next state of the whole block
  always_comb begin
    logic       do_write;
    logic       transmit_enable_one;
    logic       phy_set;
    logic       early_set;
    logic       abort_set;
    logic       drained_set;
    logic [7:0] widx;
    logic [7:0] ridx;
    do_write    = 1'b0;
    transmit_enable_one   = 1'b0;
    phy_set     = 1'b0;
    early_set   = 1'b0;
    abort_set   = 1'b0;
    drained_set = 1'b0;
    widx        = {2'h0, s.awaddr[7:2]};
    ridx        = {2'h0, s_axi_araddr[7:2]};
    next_s      = s;
    ack_fire    = 1'b0;
    ack_val     = 8'h00;
    mask_we     = 1'b0;
    mask_val    = s.mask;
    phy_read    = 1'b0;
    fatal       = transmit_underrun | sqe_error | carrier_lost | late_collision | sixteen_collisions;

    // write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_full = 1'b1;
      next_s.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_full = 1'b1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // execute a write once address and data are both held
    if (s.aw_full && s.w_full && !s.bvalid) begin
      do_write       = 1'b1;
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = RESP_OKAY;
    end
    if (do_write) begin
      case (widx)
        IDX_STATUS: begin
          ack_fire = s.wstrb[0];
          ack_val  = s.wstrb[0] ? s.wdata[7:0] : 8'h00;
          if (s.wstrb[1]) begin
            mask_we  = 1'b1;
            mask_val = s.wdata[15:8];
          end
        end
        IDX_MASK: begin
          if (s.wstrb[0]) begin
            mask_we  = 1'b1;
            mask_val = s.wdata[7:0];
          end
        end
        IDX_CONTROL: begin
          if (s.wstrb[0]) begin
            next_s.thresh  = s.wdata[CTL_THRESH_MSB:CTL_THRESH_LSB];
            next_s.discard = s.wdata[CTL_DISCARD];
          end
          if (s.wstrb[1]) begin
            next_s.le_en = s.wdata[CTL_LE];
            next_s.cr_en = s.wdata[CTL_CR];
            next_s.te_en = s.wdata[CTL_TE];
            next_s.tx_en = s.wdata[CTL_TRANSMIT_ENABLE];
            transmit_enable_one    = s.wdata[CTL_TRANSMIT_ENABLE];
          end
        end
        IDX_PHY: begin
          next_s.bresp = RESP_OKAY;
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (mask_we) begin
      next_s.mask = mask_val;
    end

    // read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      case (ridx)
        IDX_STATUS:  next_s.rdata = {16'h0000, s.mask, s.status};
        IDX_MASK:    next_s.rdata = {24'h000000, s.mask};
        IDX_CONTROL: next_s.rdata = {20'h00000, s.tx_en, s.te_en, s.cr_en, s.le_en,
                                     s.discard, 2'h0, s.thresh};
        IDX_PHY: begin
          next_s.rdata = {22'h000000, s.phy_held, s.phy_shown};
          phy_read     = 1'b1;
        end
        default: begin
          next_s.rdata = 32'h00000000;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end

    // phy bits: two-flop sync, then latch on change until read
    next_s.phy_sync1 = phy_status_bits;
    next_s.phy_sync2 = s.phy_sync1;
    if (phy_read) begin
      next_s.phy_shown = s.phy_sync2;
      next_s.phy_held  = 1'b0;
    end else if (!s.phy_held && (s.phy_sync2 != s.phy_shown)) begin
      next_s.phy_shown = s.phy_sync2;
      next_s.phy_held  = 1'b1;
      phy_set          = 1'b1;
    end

    // fatal error stops the transmitter
    if (frame_sent) begin
      next_s.tx_success = 1'b1;
    end
    if (fatal) begin
      next_s.tx_en      = 1'b0;
      next_s.tx_success = 1'b0;
    end

    // handler sub-sources, each cleared at its own source
    next_s.link_pend = sticky(s.link_pend, link_event & s.le_en, ~next_s.le_en);
    next_s.roll_pend = sticky(s.roll_pend, counter_rollover & s.cr_en, counter_read);
    next_s.err_pend  = sticky(s.err_pend, fatal & s.te_en, transmit_enable_one);

    // early receive compare in 64 byte units
    early_set = receiving && (rx_byte_count > thresh_bytes(s.thresh));

    // receive abort causes; discard self-clears after one cycle
    abort_set      = rx_alloc_overrun | rx_too_long | (s.discard & receiving);
    next_s.discard = do_write && (widx == IDX_CONTROL) && s.wstrb[0] ? s.wdata[CTL_DISCARD] : 1'b0;

    // drained flag latches on the queue becoming empty
    drained_set       = tx_queue_empty & ~s.empty_prev;
    next_s.empty_prev = tx_queue_empty;

    // status bits, acknowledge clears only where a path exists
    next_s.status[BIT_PHY]     = sticky(s.status[BIT_PHY], phy_set, ack_val[BIT_PHY]);
    next_s.status[BIT_EARLY]   = sticky(s.status[BIT_EARLY], early_set, ack_val[BIT_EARLY]);
    next_s.status[BIT_EPH]     = next_s.link_pend | next_s.roll_pend | next_s.err_pend;
    next_s.status[BIT_ABORT]   = sticky(s.status[BIT_ABORT], abort_set, ack_val[BIT_ABORT]);
    next_s.status[BIT_ALLOC]   = alloc_request ? 1'b0 : ~alloc_failed;
    next_s.status[BIT_DRAINED] = sticky(s.status[BIT_DRAINED], drained_set, ack_val[BIT_DRAINED]);
    next_s.status[BIT_TXC]     = ~completion_queue_empty;
    next_s.status[BIT_RXP]     = ~receive_queue_empty;
    next_s.pop                 = ack_val[BIT_TXC];
  end

  // state register with synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      s            <= '0;
      s.status     <= STATUS_RESET;
      s.mask       <= MASK_RESET;
      s.thresh     <= THRESH_RESET;
      s.empty_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_IRQ_ON: assert property ((s.status[BIT_ALLOC] && s.mask[BIT_ALLOC]) |-> irq)
    else $error("unmasked status bit without interrupt");
  AST_IRQ_OFF: assert property ((s.mask == 8'h00) |-> !irq)
    else $error("interrupt with all sources masked");
  AST_MASK_WR: assert property (mask_we |=> (s.mask == $past(mask_val)))
    else $error("mask write lost");
  AST_PHY_SET: assert property ((!s.phy_held && !phy_read && (s.phy_sync2 != s.phy_shown))
    |=> (s.status[BIT_PHY] && s.phy_held))
    else $error("phy change not flagged");
  AST_PHY_CLR: assert property ($fell(s.status[BIT_PHY]) |-> $past(ack_val[BIT_PHY]))
    else $error("phy flag cleared without acknowledge");
  AST_EARLY: assert property ((receiving && (rx_byte_count > thresh_bytes(s.thresh))) |=> s.status[BIT_EARLY])
    else $error("early receive not flagged");
  AST_EPH_TE: assert property ((fatal && s.te_en) |=> s.status[BIT_EPH] ##1 (s.status[BIT_EPH] || s.tx_en))
    else $error("fatal error not flagged");
  AST_FATAL: assert property (fatal |=> (!s.tx_en && !s.tx_success))
    else $error("fatal error left transmitter on");
  AST_ROLL_HOLD: assert property ((s.roll_pend && !counter_read) |=> s.status[BIT_EPH])
    else $error("handler flag cleared without source");
  AST_ABORT: assert property ((rx_alloc_overrun || rx_too_long) |=> s.status[BIT_ABORT])
    else $error("abort not flagged");
  AST_ABORT_CLR: assert property ($fell(s.status[BIT_ABORT]) |-> $past(ack_val[BIT_ABORT]))
    else $error("abort cleared without acknowledge");
  AST_ALLOC: assert property (alloc_request |=> !s.status[BIT_ALLOC])
    else $error("allocation flag not cleared by request");
  AST_DRAINED: assert property ((tx_queue_empty && !s.empty_prev) |=> s.status[BIT_DRAINED])
    else $error("drained edge not latched");
  AST_TXC: assert property (1'b1 |=> (s.status[BIT_TXC] == !$past(completion_queue_empty)))
    else $error("transmit complete not inverse of queue empty");
  AST_POP: assert property ((ack_fire && ack_val[BIT_TXC]) |=> completion_pop ##1 !completion_pop)
    else $error("completion pop not a single pulse");
  AST_RXP: assert property ((ack_val[BIT_RXP] && !receive_queue_empty) |=> s.status[BIT_RXP])
    else $error("receive pending cleared by acknowledge");
  AST_ACK_ZERO: assert property ((s.status[BIT_EARLY] && !ack_val[BIT_EARLY]) |=> s.status[BIT_EARLY])
    else $error("early flag cleared without acknowledge");
  AST_BHOLD: assert property ((s.bvalid && !s_axi_bready) |=> (s.bvalid && $stable(s.bresp)))
    else $error("write response dropped");
  // flags and outputs that only their own source may change
  AST_TXSUC: assert property ((frame_sent && !fatal) |=> transmit_success)
    else $error("sent frame did not set transmit success");
  AST_LINK_OFF: assert property ((!s.le_en && !$past(s.le_en)) |-> !s.link_pend)
    else $error("link event pending while its enable is low");
  AST_DISCARD: assert property ((s.discard && receiving) |=> s.status[BIT_ABORT])
    else $error("discarded frame not flagged as abort");
  AST_DRAINED_HOLD: assert property ((s.status[BIT_DRAINED] && !ack_val[BIT_DRAINED])
    |=> s.status[BIT_DRAINED])
    else $error("drained flag dropped without acknowledge");
  AST_NO_POP: assert property (!ack_val[BIT_TXC] |=> !completion_pop)
    else $error("completion pop without acknowledge");
  AST_RXP_CLR: assert property (receive_queue_empty |=> !s.status[BIT_RXP])
    else $error("receive pending with empty queue");

  COV_IRQ: cover property ($rose(irq));
  COV_POP: cover property (ack_fire && ack_val[BIT_TXC]);
  COV_DISCARD: cover property (s.discard && receiving);
  COV_FATAL: cover property (fatal && s.te_en);
  COV_PHY: cover property (s.status[BIT_PHY] ##[1:20] phy_read);
endmodule : ethernet_ctrl_interrupt_unit
`default_nettype wire

//--- host_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the register bus: one write and one read at a time
module host_bus_model (
  input  wire logic        clk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  end

  // released payload shows its inverse so a stale value is never mistaken
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s, output logic [1:0] rs);
    logic ap;
    logic wp;
    ap = 1'b1;
    wp = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (ap || wp) begin
      @(posedge clk);
      if (ap && s_axi_awready) begin
        ap = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (wp && s_axi_wready) begin
        wp = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~dt;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  // read: hold address until taken, rready until data seen
  task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    dt = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : rd
endmodule : host_bus_model
`default_nettype wire

//--- ethernet_ctrl_interrupt_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ethernet_ctrl_interrupt_unit_tb;
  import irq_unit_pkg::*;
  typedef struct { int ev; int arg; logic [7:0] e1; logic [7:0] ack; logic [7:0] e2; } row_s;
  localparam logic [7:0] A_ST = 8'h30;
  localparam logic [7:0] A_MSK = 8'h34;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic [7:0]            s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata, d;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp, r;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [PHY_BITS-1:0]   phy_status_bits = '0;
  logic                  receiving = 1'b1;
  logic [BYTE_CNT_W-1:0] rx_byte_count = '0;
  logic [6:0]            pls = '0;
  logic [4:0]            fatal = '0;
  logic                  tx_queue_empty = 1'b1, completion_queue_empty = 1'b1;
  logic                  receive_queue_empty = 1'b1, alloc_failed = 1'b1;
  logic                  completion_pop, receive_discard, transmit_enable, transmit_success, irq;
  logic [7:0]            mask = 8'hFF;
  int                    err_count = 0, tests_run = 0, cyc = 0, pops = 0, discards = 0;
  // event code, argument, status after event, acknowledge, status after acknowledge
  row_s rows [35] = '{
    '{4, 1984, 8'h00, 8'h00, 8'h00}, '{4, 1985, 8'h40, 8'h40, 8'h00}, '{1, 0, 8'h10, 8'h10, 8'h00},
    '{1, 1, 8'h10, 8'h2D, 8'h10}, '{0, 0, 8'h10, 8'h10, 8'h00}, '{2, 128, 8'h10, 8'h10, 8'h00},
    '{3, 0, 8'h80, 8'h00, 8'h80}, '{10, 0, 8'h80, 8'h80, 8'h00}, '{5, 0, 8'h04, 8'h04, 8'h00},
    '{6, 0, 8'h02, 8'h00, 8'h02}, '{6, 0, 8'h00, 8'h00, 8'h00}, '{7, 0, 8'h01, 8'h01, 8'h01},
    '{7, 0, 8'h00, 8'h00, 8'h00}, '{8, 0, 8'h08, 8'h08, 8'h08}, '{1, 6, 8'h08, 8'h00, 8'h08},
    '{8, 0, 8'h00, 8'h00, 8'h00}, '{2, 256, 8'h00, 8'h00, 8'h00}, '{1, 2, 8'h20, 8'h20, 8'h20},
    '{2, 0, 8'h00, 8'h00, 8'h00}, '{2, 512, 8'h00, 8'h00, 8'h00}, '{1, 3, 8'h20, 8'h00, 8'h20},
    '{1, 4, 8'h00, 8'h00, 8'h00}, '{2, 3072, 8'h00, 8'h00, 8'h00}, '{9, 0, 8'h20, 8'h20, 8'h20},
    '{2, 3072, 8'h00, 8'h00, 8'h00}, '{9, 1, 8'h20, 8'h20, 8'h20}, '{2, 3072, 8'h00, 8'h00, 8'h00},
    '{9, 2, 8'h20, 8'h20, 8'h20}, '{2, 3072, 8'h00, 8'h00, 8'h00}, '{9, 3, 8'h20, 8'h20, 8'h20},
    '{2, 3072, 8'h00, 8'h00, 8'h00}, '{9, 4, 8'h20, 8'h20, 8'h20}, '{2, 3072, 8'h00, 8'h00, 8'h00},
    '{0, 0, 8'h00, 8'h00, 8'h00}, '{0, 0, 8'h00, 8'h00, 8'h00}};

  ethernet_ctrl_interrupt_unit i_ethernet_ctrl_interrupt_unit (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .phy_status_bits, .receiving, .rx_byte_count,
    .rx_alloc_overrun(pls[1]), .rx_too_long(pls[0]), .link_event(pls[2]), .counter_rollover(pls[3]),
    .counter_read(pls[4]), .transmit_underrun(fatal[0]), .sqe_error(fatal[1]), .carrier_lost(fatal[2]),
    .late_collision(fatal[3]), .sixteen_collisions(fatal[4]), .frame_sent(pls[5]), .alloc_request(pls[6]),
    .alloc_failed, .tx_queue_empty, .completion_queue_empty, .receive_queue_empty, .completion_pop,
    .receive_discard, .transmit_enable, .transmit_success, .irq);

  host_bus_model i_host_bus_model (
    .clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // clock, queue pop counter and hang limit
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (completion_pop === 1'b1) pops <= pops + 1;
    if (receive_discard === 1'b1) discards <= discards + 1;
    if (cyc == 6000) begin
      err_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : ck

  // status byte and the interrupt line it should give
  task automatic rs(input logic [7:0] e);
    i_host_bus_model.rd(A_ST, d, r);
    ck("status", {24'h0, e}, {24'h0, d[7:0]});
    ck("irq", 32'(|(e & mask)), 32'(irq));
  endtask : rs

  // drive one source event, then let it settle
  task automatic ev(input int c, input int a);
    case (c)
      1: begin
        pls <= 7'(1 << a);
        @(posedge clk);
        pls <= '0;
      end
      2: i_host_bus_model.wr(8'h38, 32'(a), 4'b0011, r);
      3: phy_status_bits <= ~phy_status_bits;
      4: begin
        rx_byte_count <= 11'(a);
        repeat (2) @(posedge clk);
        rx_byte_count <= '0;
      end
      5: begin
        tx_queue_empty <= 1'b0;
        @(posedge clk);
        tx_queue_empty <= 1'b1;
      end
      6: completion_queue_empty <= ~completion_queue_empty;
      7: receive_queue_empty <= ~receive_queue_empty;
      8: alloc_failed <= ~alloc_failed;
      9: begin
        pls <= 7'h20;
        @(posedge clk);
        pls <= '0;
        fatal <= 5'(1 << a);
        @(negedge clk);
        ck("txsuc1", 32'h1, 32'(transmit_success));
        ck("txena1", 32'h1, 32'(transmit_enable));
        @(posedge clk);
        fatal <= '0;
        repeat (2) @(posedge clk);
        ck("transmit_enable", 32'h0, 32'(transmit_enable));
        ck("txsuc", 32'h0, 32'(transmit_success));
      end
      10: begin
        i_host_bus_model.rd(8'h3C, d, r);
        ck("phy", 32'h1FF, 32'(d[8:0]));
      end
      default: ;
    endcase
    repeat (5) @(posedge clk);
  endtask : ev

  // reset pulse, then reset values at the status word
  task automatic rchk();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    i_host_bus_model.rd(A_ST, d, r);
    ck("reset", 32'h0000_0004, d);
    ck("irq0", 32'h0, 32'(irq));
    ck("txena0", 32'h0, 32'(transmit_enable));
  endtask : rchk

  initial begin
    rchk();
    i_host_bus_model.wr(A_ST, 32'h0000_0004, 4'b0001, r);
    i_host_bus_model.wr(A_MSK, 32'h0000_00FF, 4'b0001, r);
    for (int i = 0; i < 35; i++) begin
      ev(rows[i].ev, rows[i].arg);
      rs(rows[i].e1);
      i_host_bus_model.wr(A_ST, {24'h0, rows[i].ack}, 4'b0001, r);
      rs(rows[i].e2);
    end
    ck("discards", 32'd1, 32'(discards));
    i_host_bus_model.rd(8'h38, d, r);
    ck("control", 32'h0000_0C00, d);
    // mask as upper byte of the word and as its own byte
    i_host_bus_model.wr(A_ST, 32'h0000_A500, 4'b0010, r);
    i_host_bus_model.rd(A_MSK, d, r);
    ck("mask", 32'h0000_00A5, d);
    i_host_bus_model.wr(A_MSK, 32'h0000_005A, 4'b0001, r);
    i_host_bus_model.rd(A_ST, d, r);
    ck("word", 32'h0000_5A00, d);
    mask = 8'h5A;
    ev(6, 0);
    rs(8'h02);
    i_host_bus_model.wr(A_MSK, 32'h0000_00FD, 4'b0001, r);
    mask = 8'hFD;
    rs(8'h02);
    // acknowledging completion pops the queue once
    pops = 0;
    i_host_bus_model.wr(A_ST, 32'h0000_0002, 4'b0001, r);
    repeat (3) @(posedge clk);
    ck("pops", 32'd1, 32'(pops));
    ev(6, 0);
    // unmapped places answer with an error
    i_host_bus_model.rd(8'h40, d, r);
    ck("rresp", 32'(RESP_SLVERR), 32'(r));
    ck("rdata", 32'h0, d);
    i_host_bus_model.wr(8'h44, 32'h0000_00FF, 4'b1111, r);
    ck("bresp", 32'(RESP_SLVERR), 32'(r));
    // second reset in mid-run
    phy_status_bits <= '0;
    repeat (4) @(posedge clk);
    rchk();
    final_report();
  end
endmodule : ethernet_ctrl_interrupt_unit_tb
`default_nettype wire
